// ---- include/dsp_xfer_cfg.svh ----
/*
  Constants for the DSP register transfer formatter.
  Assumes inclusion by bare name from the package and modules.
*/
`ifndef DSP_XFER_CFG_SVH
`define DSP_XFER_CFG_SVH
`define DATA_W        32
`define ACC_W         40
`define GUARD_W       8
`define HALF_W        16
`define GUARD_LSB     32
`define UPPER_LSB     16
`define REG_COUNT     10
`define REG_RESET     32'h0000_0000
`define GUARD_RESET   8'h00
`endif

// ---- include/dsp_xfer_pkg.sv ----
/*
  Types for the DSP register transfer formatter.
  Assumes dsp_xfer_cfg.svh is on the include path.
*/
`include "dsp_xfer_cfg.svh"
package dsp_xfer_pkg;
  typedef enum logic [3:0] {
    SEL_ACC0, SEL_ACC1, SEL_ACC0_G, SEL_ACC1_G,
    SEL_X0, SEL_X1, SEL_Y0, SEL_Y1, SEL_M0, SEL_M1
  } reg_sel_t;
  typedef enum logic [1:0] {
    XFER_SINGLE_WORD, XFER_SINGLE_LONG, XFER_XMEM_WORD, XFER_YMEM_WORD
  } xfer_kind_t;
  typedef struct packed {
    logic       valid;
    logic       is_load;
    xfer_kind_t kind;
    reg_sel_t   sel;
    logic [31:0] data;
  } xfer_req_t;
  typedef struct packed {
    logic       valid;
    reg_sel_t   sel;
  } op_req_t;
  typedef enum logic {ST_IDLE, ST_BUSY} fmt_state_t;
endpackage

// ---- verilog/dsp_reg_bank.sv ----
/*
  Small register bank holding the ten DSP 32-bit words.
  Assumes one writer port with a single word enable; read data are registered.
*/
`timescale 1ns/1ps
`include "dsp_xfer_cfg.svh"
module dsp_reg_bank #(
  parameter int WIDTH = `DATA_W,
  parameter int DEPTH = `REG_COUNT
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data,
  // Whole contents for operand taps
  output logic      [DEPTH*WIDTH-1:0]   flat_q
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  if (WIDTH < 1 || DEPTH < 2) begin : g_bad_size
    $error("dsp_reg_bank: bad size");
  end

  // ========================================
  // Storage
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_word
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          mem_reg[gi] <= '0;
        end else if (wr_en && wr_addr == AW'(gi)) begin
          mem_reg[gi] <= wr_data;
        end
      end
      assign flat_q[gi*WIDTH +: WIDTH] = mem_reg[gi];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule

// ---- verilog/dsp_xfer_fmt.sv ----
/*
  DSP register transfer formatter: loads, stores and operand taps for the
  accumulators, their guard registers, and the input and multiplier registers.
  Assumes the decoder presents a valid request with its bus data in one cycle.
*/
// Functional notes
// - Word load to non-guard register: data to upper half, lower half zeroed.
// - Word load to accumulator: guard bits take data sign, lower half zeroed.
// - Guard register load stores low 8 bits; rest of accumulator kept.
// - Longword store from non-guard register drives 32 bits; guard ignored.
// - Longword store from guard register: 8 bits, sign-extended upward.
// - Longword load writes 32 bits; accumulator guard takes the sign.
// - Signed multiply accepts second accumulator, refuses the first.
// - Input and multiplier operands sign-extend into eight guard positions.
// - Word store from non-guard register outputs upper half only.
// - Word store from guard register: 8 bits, sign-extended upward.
// - X and Y memory word loads reach only X and Y registers.
`timescale 1ns/1ps
`include "dsp_xfer_cfg.svh"
module dsp_xfer_fmt
  import dsp_xfer_pkg::*;
#(
  parameter int DATA_W = `DATA_W
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Transfer request from the decoder
  input  wire xfer_req_t         xfer_in,
  // Store data to the common data bus
  output logic [DATA_W-1:0]      common_data_bus_out,
  output logic                   store_valid,
  output logic                   xfer_refused,
  // Operand request and answer
  input  wire op_req_t           op_in,
  output logic [`ACC_W-1:0]      operand_out,
  output logic                   operand_valid,
  output logic                   mul_src_refused
);
  // ========================================
  // Elaboration checks
  if (DATA_W != `DATA_W) begin : g_bad_width
    $error("dsp_xfer_fmt: only 32-bit data supported");
  end
  // Bank address is four bits wide and eight words are used
  if (`REG_COUNT < 8 || `REG_COUNT > 16) begin : g_bad_depth
    $error("dsp_xfer_fmt: register count must be 8 to 16");
  end

  // ========================================
  // Decoding helpers
  function automatic logic is_guard(input reg_sel_t s);
    return (s == SEL_ACC0_G) || (s == SEL_ACC1_G);
  endfunction

  function automatic logic is_acc(input reg_sel_t s);
    return (s == SEL_ACC0) || (s == SEL_ACC1);
  endfunction

  function automatic logic [3:0] word_index(input reg_sel_t s);
    // Guard registers share the accumulator's word slot
    case (s)
      SEL_ACC0, SEL_ACC0_G: return 4'h0;
      SEL_ACC1, SEL_ACC1_G: return 4'h1;
      SEL_X0:  return 4'h2;
      SEL_X1:  return 4'h3;
      SEL_Y0:  return 4'h4;
      SEL_Y1:  return 4'h5;
      SEL_M0:  return 4'h6;
      SEL_M1:  return 4'h7;
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [31:0] sext8(input logic [7:0] g);
    return {{24{g[7]}}, g};
  endfunction

  // ========================================
  // State
  logic [7:0]  guard0_reg;
  logic [7:0]  guard1_reg;
  logic [31:0] bank_wdata;
  logic [31:0] bank_rdata;
  logic [32*`REG_COUNT-1:0] bank_flat;
  logic [3:0]  bank_rd_addr;

  // Pipeline of a store: bank read data arrive one cycle later
  logic        st_pend_reg;
  xfer_kind_t  st_kind_reg;
  reg_sel_t    st_sel_reg;
  logic [7:0]  st_guard_reg;

  // ========================================
  // Request decode
  wire req_ok   = xfer_in.valid;
  wire req_g    = is_guard(xfer_in.sel);
  wire req_acc  = is_acc(xfer_in.sel);
  wire req_long = (xfer_in.kind == XFER_SINGLE_LONG);
  wire x_target = (xfer_in.sel == SEL_X0) || (xfer_in.sel == SEL_X1);
  wire y_target = (xfer_in.sel == SEL_Y0) || (xfer_in.sel == SEL_Y1);
  wire acc_target = req_acc;
  // Memory word loads only reach their own input pair; stores only from accumulators
  wire bad_xy = xfer_in.is_load
    ? ((xfer_in.kind == XFER_XMEM_WORD && !x_target) ||
       (xfer_in.kind == XFER_YMEM_WORD && !y_target))
    : ((xfer_in.kind == XFER_XMEM_WORD || xfer_in.kind == XFER_YMEM_WORD) &&
       !acc_target);
  wire refuse   = req_ok && bad_xy;
  wire do_load  = req_ok && xfer_in.is_load && !refuse;
  wire do_store = req_ok && !xfer_in.is_load && !refuse;
  wire bank_we  = do_load && !req_g;

  wire [31:0] word_load = {xfer_in.data[31:16], 16'h0000};
  assign bank_wdata = req_long ? xfer_in.data : word_load;
  assign bank_rd_addr = word_index(xfer_in.sel);

  // Accumulator guard follows the loaded word's sign
  wire [7:0] load_sign = {8{bank_wdata[31]}};

  dsp_reg_bank #(
    .WIDTH (32),
    .DEPTH (`REG_COUNT)
  ) u_bank (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wr_en    (bank_we),
    .wr_addr  (word_index(xfer_in.sel)),
    .wr_data  (bank_wdata),
    .rd_addr  (bank_rd_addr),
    .rd_data  (bank_rdata),
    .flat_q   (bank_flat)
  );

  // ========================================
  // Guard registers
  wire g0_we_direct = do_load && xfer_in.sel == SEL_ACC0_G;
  wire g1_we_direct = do_load && xfer_in.sel == SEL_ACC1_G;
  wire g0_we_sign   = do_load && xfer_in.sel == SEL_ACC0;
  wire g1_we_sign   = do_load && xfer_in.sel == SEL_ACC1;

  // A direct guard load leaves the accumulator word alone
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      guard0_reg <= `GUARD_RESET;
      guard1_reg <= `GUARD_RESET;
    end else begin
      if (g0_we_direct) begin
        guard0_reg <= xfer_in.data[7:0];
      end else if (g0_we_sign) begin
        guard0_reg <= load_sign;
      end
      if (g1_we_direct) begin
        guard1_reg <= xfer_in.data[7:0];
      end else if (g1_we_sign) begin
        guard1_reg <= load_sign;
      end
    end
  end

  // ========================================
  // Store path
  wire [7:0] guard_pick = (xfer_in.sel == SEL_ACC1_G) ? guard1_reg : guard0_reg;
  // Guard rides with the request so a later guard load cannot leak in
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_pend_reg  <= 1'b0;
      st_kind_reg  <= XFER_SINGLE_WORD;
      st_sel_reg   <= SEL_ACC0;
      st_guard_reg <= `GUARD_RESET;
    end else begin
      st_pend_reg  <= do_store;
      st_kind_reg  <= xfer_in.kind;
      st_sel_reg   <= xfer_in.sel;
      st_guard_reg <= guard_pick;
    end
  end

  // Word stores put the upper half in the low bus half, sign-extended
  wire [31:0] store_word = {{16{bank_rdata[31]}}, bank_rdata[31:16]};
  wire [31:0] store_data = is_guard(st_sel_reg) ? sext8(st_guard_reg)
                         : (st_kind_reg == XFER_SINGLE_LONG) ? bank_rdata
                         : store_word;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      common_data_bus_out <= `REG_RESET;
      store_valid         <= 1'b0;
      xfer_refused        <= 1'b0;
    end else begin
      store_valid  <= st_pend_reg;
      xfer_refused <= refuse;
      if (st_pend_reg) begin
        common_data_bus_out <= store_data;
      end
    end
  end

  // ========================================
  // Operand taps
  // Taps read the bank directly, so a load one cycle earlier is seen
  wire [31:0] op_word  = bank_flat[32*word_index(op_in.sel) +: 32];
  wire        op_acc0  = op_in.sel == SEL_ACC0;
  wire        op_acc1  = op_in.sel == SEL_ACC1;
  wire        op_bad   = op_in.valid && (op_acc0 || is_guard(op_in.sel));
  wire [7:0]  op_guard = op_acc0 ? guard0_reg
                       : op_acc1 ? guard1_reg
                       : {8{op_word[31]}};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      operand_out     <= '0;
      operand_valid   <= 1'b0;
      mul_src_refused <= 1'b0;
    end else begin
      operand_valid   <= op_in.valid && !op_bad;
      mul_src_refused <= op_bad;
      if (op_in.valid && !op_bad) begin
        operand_out <= {op_guard, op_word};
      end
    end
  end
endmodule

// ---- tb/dsp_decoder_model.sv ----
/* Decoder model issuing transfer and operand requests.
   Assumes bench calls; drives on the falling edge. */
`timescale 1ns/1ps
module dsp_decoder_model
  import dsp_xfer_pkg::*;
(
  // Clock
  input  wire logic core_clk,
  // Requests
  output xfer_req_t  xfer_in,
  output op_req_t    op_in
);
  initial begin
    xfer_in = '0;
    op_in   = '0;
  end
  // ====================
  // Request tasks
  task automatic xfer(input logic l, input xfer_kind_t k, input reg_sel_t s,
                      input logic [31:0] d);
    @(negedge core_clk);
    xfer_in <= '{1'b1, l, k, s, d};
    op_in.valid <= 1'b0;
  endtask
  task automatic op(input reg_sel_t s);
    @(negedge core_clk);
    op_in <= '{1'b1, s};
    xfer_in.valid <= 1'b0;
  endtask
  // Released bus inverts, so stale data cannot pass
  task automatic idle();
    @(negedge core_clk);
    xfer_in.valid <= 1'b0;
    xfer_in.data  <= ~xfer_in.data;
    op_in.valid   <= 1'b0;
  endtask
endmodule

// ---- tb/dsp_xfer_fmt_sva.sv ----
/* Checker on the formatter ports.
   Assumes one clock and active-low reset. */
`timescale 1ns/1ps
module dsp_xfer_fmt_sva
  import dsp_xfer_pkg::*;
#(parameter int DATA_W = 32) (
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire xfer_req_t         xfer_in,
  input wire logic [DATA_W-1:0] common_data_bus_out,
  input wire logic              store_valid,
  input wire logic              xfer_refused,
  input wire op_req_t           op_in,
  input wire logic [39:0]       operand_out,
  input wire logic              operand_valid,
  input wire logic              mul_src_refused
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire st = xfer_in.valid && !xfer_in.is_load &&
    (xfer_in.kind inside {XFER_SINGLE_WORD, XFER_SINGLE_LONG});
  wire gs = xfer_in.sel == SEL_ACC0_G || xfer_in.sel == SEL_ACC1_G;
  wire ld = xfer_in.valid && xfer_in.is_load;
  a_store_latency: assert property (st |-> ##2 store_valid)
    else $error("store answer late");
  a_guard_store_ext: assert property (st && gs |-> ##2
    common_data_bus_out[31:8] == {24{common_data_bus_out[7]}}) else $error("guard ext");
  a_word_store_half: assert property (st && !gs && xfer_in.kind == XFER_SINGLE_WORD
    |-> ##2 common_data_bus_out[31:16] == {16{common_data_bus_out[15]}}) else $error("word st");
  a_mul_acc0_refused: assert property (op_in.valid && op_in.sel == SEL_ACC0
    |=> mul_src_refused && !operand_valid) else $error("acc0 source taken");
  a_mul_acc1_taken: assert property (op_in.valid && op_in.sel == SEL_ACC1
    |=> operand_valid && !mul_src_refused) else $error("acc1 source refused");
  a_operand_sign_ext: assert property (op_in.valid && op_in.sel >= SEL_X0 |=>
    operand_valid && operand_out[39:32] == {8{operand_out[31]}}) else $error("operand ext");
  a_xmem_refused: assert property (ld && xfer_in.kind == XFER_XMEM_WORD &&
    !(xfer_in.sel inside {SEL_X0, SEL_X1}) |=> xfer_refused) else $error("x load");
  a_ymem_refused: assert property (ld && xfer_in.kind == XFER_YMEM_WORD &&
    !(xfer_in.sel inside {SEL_Y0, SEL_Y1}) |=> xfer_refused) else $error("y load");
endmodule
bind dsp_xfer_fmt dsp_xfer_fmt_sva #(.DATA_W(DATA_W)) i_dsp_xfer_fmt_sva (.*);

// ---- tb/dsp_xfer_fmt_tb_top.sv ----
/* Bench for the transfer formatter.
   Assumes the decoder model drives all requests. */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module dsp_xfer_fmt_tb_top;
  import dsp_xfer_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  xfer_req_t   xfer_in;
  op_req_t     op_in;
  logic [31:0] bus;
  logic [39:0] opnd;
  logic        sv, rf, ov, mr;
  int          n_errors = 0, num_checks = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  dsp_decoder_model i_dsp_decoder_model (.core_clk(core_clk), .xfer_in(xfer_in),
    .op_in(op_in));
  dsp_xfer_fmt i_dsp_xfer_fmt (.core_clk(core_clk), .nrst(nrst), .xfer_in(xfer_in),
    .common_data_bus_out(bus), .store_valid(sv), .xfer_refused(rf), .op_in(op_in),
    .operand_out(opnd), .operand_valid(ov), .mul_src_refused(mr));
  // ====================
  // Shared steps
  task automatic ld(input xfer_kind_t k, input reg_sel_t s, input logic [31:0] d);
    i_dsp_decoder_model.xfer(1'b1, k, s, d);
  endtask
  task automatic st(input xfer_kind_t k, input reg_sel_t s, input logic [31:0] e);
    i_dsp_decoder_model.xfer(1'b0, k, s, 32'h0);
    i_dsp_decoder_model.idle();
    @(negedge core_clk);
    `CHK(sv, 1'b1)
    `CHK(bus, e)
  endtask
  task automatic opc(input reg_sel_t s, input logic v, input logic [39:0] e);
    i_dsp_decoder_model.op(s);
    i_dsp_decoder_model.idle();
    `CHK(ov, v)
    if (v) `CHK(opnd, e) else `CHK(mr, 1'b1)
  endtask
  // ====================
  // Scenarios
  task automatic t_word();
    ld(XFER_SINGLE_WORD, SEL_X0, 32'h8765_4321);
    st(XFER_SINGLE_LONG, SEL_X0, 32'h8765_0000);
    st(XFER_SINGLE_WORD, SEL_X0, 32'hffff_8765);
    ld(XFER_SINGLE_WORD, SEL_ACC0, 32'h8001_1234);
    st(XFER_SINGLE_LONG, SEL_ACC0_G, 32'hffff_ffff);
    st(XFER_SINGLE_LONG, SEL_ACC0, 32'h8001_0000);
    opc(SEL_ACC0, 1'b0, 40'h0);
  endtask
  task automatic t_long();
    ld(XFER_SINGLE_LONG, SEL_ACC1, 32'h1234_5678);
    opc(SEL_ACC1, 1'b1, 40'h00_1234_5678);
    ld(XFER_SINGLE_LONG, SEL_ACC1, 32'h9234_5678);
    ld(XFER_SINGLE_WORD, SEL_ACC1_G, 32'h0000_0055);
    opc(SEL_ACC1, 1'b1, 40'h55_9234_5678);
    st(XFER_SINGLE_WORD, SEL_ACC1_G, 32'h0000_0055);
    ld(XFER_SINGLE_LONG, SEL_ACC1_G, 32'h0000_1280);
    st(XFER_SINGLE_LONG, SEL_ACC1_G, 32'hffff_ff80);
    st(XFER_SINGLE_LONG, SEL_ACC1, 32'h9234_5678);
    opc(SEL_ACC0_G, 1'b0, 40'h0);
  endtask
  task automatic t_oper();
    ld(XFER_SINGLE_LONG, SEL_M1, 32'h8000_0001);
    opc(SEL_M1, 1'b1, 40'hff_8000_0001);
    ld(XFER_SINGLE_LONG, SEL_Y0, 32'h0000_7fff);
    opc(SEL_Y0, 1'b1, 40'h00_0000_7fff);
  endtask
  task automatic t_xy();
    ld(XFER_XMEM_WORD, SEL_X1, 32'habcd_1234);
    st(XFER_SINGLE_LONG, SEL_X1, 32'habcd_0000);
    ld(XFER_XMEM_WORD, SEL_Y0, 32'h1111_2222);
    i_dsp_decoder_model.idle();
    `CHK(rf, 1'b1)
    st(XFER_SINGLE_LONG, SEL_Y0, 32'h0000_7fff);
    ld(XFER_YMEM_WORD, SEL_Y1, 32'h4321_8765);
    st(XFER_SINGLE_WORD, SEL_Y1, 32'h0000_4321);
    st(XFER_XMEM_WORD, SEL_ACC0, 32'hffff_8001);
    i_dsp_decoder_model.xfer(1'b0, XFER_YMEM_WORD, SEL_X0, 32'h0);
    i_dsp_decoder_model.idle();
    `CHK(rf, 1'b1)
    @(negedge core_clk);
    `CHK(sv, 1'b0)
  endtask
  task automatic t_rst();
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    `CHK(bus, 32'h0)
    st(XFER_SINGLE_LONG, SEL_ACC1_G, 32'h0);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Ceiling well above the fewer than a hundred cycles used
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    `CHK(sv, 1'b0)
    t_word();
    t_long();
    t_oper();
    t_xy();
    t_rst();
    stop_test();
  end
endmodule
